// [hdl/debug_vis_pkg.sv]
// Purpose: shared constants and types for the debug visibility block
// Assumes: byte-wide configuration registers at 12-bit offsets
// Notes:   all offsets, bit positions and reset values live here
package debug_vis_pkg;

	localparam int unsigned REG_ADDR_W = 12;
	localparam int unsigned REG_DATA_W = 8;

	// Register offsets
	localparam logic [11:0] ECC_OVERRIDE_OFFSET = 12'h023;
	localparam logic [11:0] SDRAM_BUF_OFFSET    = 12'h040;
	localparam logic [11:0] ARB_MODE_OFFSET     = 12'h070;
	localparam logic [11:0] ADDR_DECODE_OFFSET  = 12'h080;
	localparam logic [11:0] ECHO_OFFSET         = 12'hC00;
	localparam logic [11:0] RESET_CFG_OFFSET    = 12'hD72;
	localparam logic [11:0] RESET_STATUS_OFFSET = 12'hD74;
	// Violation address, four bytes, low byte first
	localparam logic [11:0] VIOL_ADDR_OFFSET    = 12'hD80;

	// Field positions
	localparam int unsigned CONCURRENT_ARB_BIT = 0;
	localparam int unsigned PERIPH_ECHO_BIT    = 0;
	localparam int unsigned WRITE_BUFFER_BIT   = 0;
	localparam int unsigned DEBUG_ENTRY_BIT    = 0;
	localparam int unsigned WP_IRQ_BIT         = 0;
	localparam int unsigned NX_CHECK_BIT       = 1;

	// Reset values
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
	// Byte masks that make the SDRAM drop the write data
	localparam logic [3:0]  MASK_DISCARD = 4'hF;

	typedef struct packed {
		logic [11:0] addr;
		logic        write;
		logic        read;
		logic [7:0]  wdata;
	} reg_req_type;

	typedef struct packed {
		logic cpu;
		logic pci;
		logic dma;
	} bus_req_type;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [15:0] data;
		logic        data_oe;
	} gp_bus_type;

	typedef enum logic [1:0] {
		OWN_NONE = 2'b00,
		OWN_CPU  = 2'b01,
		OWN_PCI  = 2'b11,
		OWN_DMA  = 2'b10
	} owner_type;

	typedef enum logic [1:0] {
		ECHO_IDLE   = 2'b00,
		ECHO_STROBE = 2'b01,
		ECHO_FINISH = 2'b11
	} echo_state_type;

endpackage

// [hdl/gp_echo_engine.sv]
// Purpose: mirrors internal peripheral accesses as general-purpose bus cycles
// Assumes: start is a one-cycle pulse per peripheral access
// Notes:   while disabled the native completion passes straight through
`timescale 1ns/1ps
module gp_echo_engine (
	input  wire logic                     clock,        // System clock
	input  wire logic                     reset,        // Async reset
	input  wire logic                     enable,       // Echo enabled
	input  wire logic                     start,        // Access start
	input  wire logic [15:0]              start_addr,   // Access address
	input  wire logic                     start_write,  // Access is write
	input  wire logic [15:0]              start_wdata,  // CPU write data
	input  wire logic [15:0]              periph_rdata, // Peripheral data
	input  wire logic                     native_done,  // Native completion
	input  wire logic [7:0]               cycle_clocks, // GP cycle length
	output logic                          done,         // Access complete
	output debug_vis_pkg::gp_bus_type     gp_bus        // Echoed GP cycle
);
	import debug_vis_pkg::*;

	typedef struct packed {
		echo_state_type state;
		logic [7:0]     count;
		gp_bus_type     bus;
	} echo_regs_type;

	echo_regs_type state_reg;
	echo_regs_type state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg.state)
			ECHO_IDLE: begin
				if (enable && start) begin
					state_next.state = ECHO_STROBE;
					state_next.count = cycle_clocks;
					state_next.bus.addr = start_addr;
					state_next.bus.rd = ~start_write;
					state_next.bus.wr = start_write;
					state_next.bus.data = start_write ? start_wdata : 16'h0000;
					state_next.bus.data_oe = 1'b1;
				end
			end
			ECHO_STROBE: begin
				// Read data follows the peripheral onto the data lines
				if (state_reg.bus.rd) begin
					state_next.bus.data = periph_rdata;
				end
				if (state_reg.count <= 8'h01) begin
					state_next.state = ECHO_FINISH;
				end else begin
					state_next.count = state_reg.count - 8'h01;
				end
			end
			ECHO_FINISH: begin
				state_next.state = ECHO_IDLE;
				state_next.bus.rd = 1'b0;
				state_next.bus.wr = 1'b0;
				state_next.bus.data_oe = 1'b0;
			end
			default: begin
				state_next.state = ECHO_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// R7 echo cycle timing
	assign done = enable ? (state_reg.state == ECHO_FINISH) : native_done;
	assign gp_bus = state_reg.bus;

endmodule

// [hdl/debug_visibility.sv]
// Purpose: debug aids programmed through byte-wide configuration registers
// Assumes: all request inputs are on the system clock
// Notes:   register reads answer one clock after the read strobe
`timescale 1ns/1ps
// Operation
// R1 - Reset leaves arbitration nonconcurrent until concurrent enable is set.
// R2 - Concurrent mode lets CPU-bus and PCI transactions run together.
// R3 - Nonconcurrent mode owns both buses before any transaction begins.
// R4 - A lone requester in nonconcurrent mode is granted with no delay.
// R5 - Echo enable mirrors peripheral accesses as general-purpose bus cycles.
// R6 - Echoed reads drive peripheral read data onto the bus data lines.
// R7 - With echo on, peripheral accesses last the programmed bus cycle time.
// R8 - Clearing write-buffer enable turns off write and read buffers.
// R9 - Debug entry bit sends the CPU to debug after each reset sequence.
// R10 - Cause of the latest reset is kept in a readable status register.
// R11 - Override check code replaces the generated ECC for the next write.
// R12 - Writes by any master to write-protected regions raise a violation.
// R13 - Violating writes reach SDRAM with all byte masks discarding data.
// R14 - First violating address is held until cleared; later ones are lost.
// R15 - Decode control enables violation interrupt and no-execute checks.
// R16 - Code fetch from a non-executable region raises a violation.
// R17 - Peripheral echo is off after reset.
// R18 - Write and read buffers are off after reset.
// R19 - Violation interrupt disabled and no protected regions after reset.
// R20 - Echo cycles carry the mirrored access's address and direction.
module debug_visibility (
	input  wire logic                      clock,            // 200 MHz
	input  wire logic                      reset,            // Async, high
	input  debug_vis_pkg::reg_req_type     reg_req,          // Reg access
	output logic [7:0]                     reg_rdata,        // Read data
	input  debug_vis_pkg::bus_req_type     bus_req,          // Bus requests
	output debug_vis_pkg::bus_req_type     bus_grant,        // Bus grants
	output logic                           both_buses_owned, // Lock both
	input  wire logic                      periph_start,     // Periph access
	input  wire logic [15:0]               periph_addr,      // Its address
	input  wire logic                      periph_write,     // Its direction
	input  wire logic [15:0]               periph_wdata,     // Write data
	input  wire logic [15:0]               periph_rdata,     // Read data
	input  wire logic                      periph_native_done, // Native end
	input  wire logic [7:0]                gp_cycle_clocks,  // GP timing
	output logic                           periph_done,      // Access end
	output debug_vis_pkg::gp_bus_type      gp_bus,           // Echo cycle
	output logic                           write_buffer_enable, // WB on
	output logic                           read_buffer_enable,  // RB on
	input  wire logic                      reset_seq_done,   // Pulse
	input  wire logic                      reset_cause_valid, // Pulse
	input  wire logic [7:0]                reset_cause,      // Source bits
	output logic                           debug_entry_request, // Pulse
	input  wire logic                      sdram_write_done, // Pulse
	output logic                           ecc_override_active, // Armed
	output logic [7:0]                     ecc_override_code, // Code
	input  wire logic                      mem_write_valid,  // Any master
	input  wire logic [31:0]               mem_write_addr,   // Write addr
	input  wire logic                      mem_write_protected, // Attr
	input  wire logic [3:0]                sdram_mask_in,    // Normal masks
	output logic [3:0]                     sdram_byte_masks, // To SDRAM
	output logic                           wp_violation,     // Pulse
	output logic                           wp_violation_irq, // Level
	input  wire logic                      fetch_valid,      // Code fetch
	input  wire logic                      fetch_non_exec,   // Attr
	output logic                           nx_violation      // Pulse
);
	import debug_vis_pkg::*;

	typedef struct packed {
		logic [7:0]  ecc_code;
		logic [7:0]  buf_ctl;
		logic [7:0]  arb_ctl;
		logic [7:0]  decode_ctl;
		logic [7:0]  echo_ctl;
		logic [7:0]  reset_cfg;
		logic [7:0]  reset_status;
		logic [31:0] viol_addr;
		logic        viol_held;
		logic        ecc_armed;
		owner_type   owner;
		logic        debug_entry;
		logic        wp_pulse;
		logic        nx_pulse;
		logic [7:0]  rdata;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic        concurrent;
	logic        echo_on;
	logic        wp_hit;
	logic        viol_clear;
	owner_type   pick;
	owner_type   owner_now;
	logic [7:0]  read_mux;

	assign concurrent = state_reg.arb_ctl[CONCURRENT_ARB_BIT];
	assign echo_on = state_reg.echo_ctl[PERIPH_ECHO_BIT];

	// R12 protected write
	assign wp_hit = mem_write_valid & mem_write_protected;
	assign viol_clear = reg_req.write
		&& (reg_req.addr == VIOL_ADDR_OFFSET);

	// Fixed priority among requesters in nonconcurrent mode
	always_comb begin
		if (bus_req.cpu) begin
			pick = OWN_CPU;
		end else if (bus_req.pci) begin
			pick = OWN_PCI;
		end else if (bus_req.dma) begin
			pick = OWN_DMA;
		end else begin
			pick = OWN_NONE;
		end
	end

	// R4 immediate grant
	always_comb begin
		unique case (state_reg.owner)
			OWN_CPU: owner_now = bus_req.cpu ? OWN_CPU : pick;
			OWN_PCI: owner_now = bus_req.pci ? OWN_PCI : pick;
			OWN_DMA: owner_now = bus_req.dma ? OWN_DMA : pick;
			OWN_NONE: owner_now = pick;
		endcase
	end

	always_comb begin
		if (concurrent) begin
			// R2 buses run independently
			bus_grant.cpu = bus_req.cpu;
			bus_grant.pci = bus_req.pci;
			bus_grant.dma = bus_req.dma & ~bus_req.cpu;
			both_buses_owned = 1'b0;
		end else begin
			// R3 one owner holds both buses
			bus_grant.cpu = (owner_now == OWN_CPU);
			bus_grant.pci = (owner_now == OWN_PCI);
			bus_grant.dma = (owner_now == OWN_DMA);
			both_buses_owned = (owner_now != OWN_NONE);
		end
	end

	always_comb begin
		unique case (reg_req.addr)
			ECC_OVERRIDE_OFFSET: read_mux = state_reg.ecc_code;
			SDRAM_BUF_OFFSET: read_mux = state_reg.buf_ctl;
			ARB_MODE_OFFSET: read_mux = state_reg.arb_ctl;
			ADDR_DECODE_OFFSET: read_mux = state_reg.decode_ctl;
			ECHO_OFFSET: read_mux = state_reg.echo_ctl;
			RESET_CFG_OFFSET: read_mux = state_reg.reset_cfg;
			RESET_STATUS_OFFSET: read_mux = state_reg.reset_status;
			VIOL_ADDR_OFFSET: read_mux = state_reg.viol_addr[7:0];
			VIOL_ADDR_OFFSET + 12'h001: read_mux = state_reg.viol_addr[15:8];
			VIOL_ADDR_OFFSET + 12'h002: read_mux = state_reg.viol_addr[23:16];
			VIOL_ADDR_OFFSET + 12'h003: read_mux = state_reg.viol_addr[31:24];
			default: read_mux = 8'h00;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		state_next.wp_pulse = 1'b0;
		state_next.nx_pulse = 1'b0;
		state_next.debug_entry = 1'b0;
		state_next.owner = concurrent ? OWN_NONE : owner_now;

		if (reg_req.read) begin
			state_next.rdata = read_mux;
		end

		if (reg_req.write) begin
			unique case (reg_req.addr)
				ECC_OVERRIDE_OFFSET: begin
					state_next.ecc_code = reg_req.wdata;
					state_next.ecc_armed = 1'b1;
				end
				SDRAM_BUF_OFFSET: state_next.buf_ctl = reg_req.wdata;
				// R1 concurrent enable
				ARB_MODE_OFFSET: state_next.arb_ctl = reg_req.wdata;
				// R15 decode control
				ADDR_DECODE_OFFSET: state_next.decode_ctl = reg_req.wdata;
				ECHO_OFFSET: state_next.echo_ctl = reg_req.wdata;
				RESET_CFG_OFFSET: state_next.reset_cfg = reg_req.wdata;
				default: begin
				end
			endcase
		end

		// R11 one write only; a new code written now stays armed
		if (sdram_write_done && state_reg.ecc_armed
			&& !(reg_req.write && reg_req.addr == ECC_OVERRIDE_OFFSET)) begin
			state_next.ecc_armed = 1'b0;
		end

		// R10 latest reset cause
		if (reset_cause_valid) begin
			state_next.reset_status = reset_cause;
		end

		// R9 debug after reset
		if (reset_seq_done && state_reg.reset_cfg[DEBUG_ENTRY_BIT]) begin
			state_next.debug_entry = 1'b1;
		end

		// R14 first address held; a new hit beats a clear
		if (viol_clear) begin
			state_next.viol_held = 1'b0;
		end
		if (wp_hit) begin
			state_next.wp_pulse = 1'b1;
			if (!state_reg.viol_held || viol_clear) begin
				state_next.viol_addr = mem_write_addr;
				state_next.viol_held = 1'b1;
			end
		end

		// R16 fetch check
		if (fetch_valid && fetch_non_exec
			&& state_reg.decode_ctl[NX_CHECK_BIT]) begin
			state_next.nx_pulse = 1'b1;
		end
	end

	// R17 R18 R19 all controls clear at reset
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg.ecc_code <= REG_RESET;
			state_reg.buf_ctl <= REG_RESET;
			state_reg.arb_ctl <= REG_RESET;
			state_reg.decode_ctl <= REG_RESET;
			state_reg.echo_ctl <= REG_RESET;
			state_reg.reset_cfg <= REG_RESET;
			state_reg.reset_status <= REG_RESET;
			state_reg.viol_addr <= ADDR_RESET;
			state_reg.viol_held <= 1'b0;
			state_reg.ecc_armed <= 1'b0;
			state_reg.owner <= OWN_NONE;
			state_reg.debug_entry <= 1'b0;
			state_reg.wp_pulse <= 1'b0;
			state_reg.nx_pulse <= 1'b0;
			state_reg.rdata <= REG_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;

	// R8 one bit gates both buffers
	assign write_buffer_enable = state_reg.buf_ctl[WRITE_BUFFER_BIT];
	assign read_buffer_enable = state_reg.buf_ctl[WRITE_BUFFER_BIT];

	assign debug_entry_request = state_reg.debug_entry;
	assign ecc_override_active = state_reg.ecc_armed;
	assign ecc_override_code = state_reg.ecc_code;

	// R13 write forwarded, data dropped
	assign sdram_byte_masks = wp_hit ? MASK_DISCARD : sdram_mask_in;

	assign wp_violation = state_reg.wp_pulse;
	// R15 interrupt gate
	assign wp_violation_irq = state_reg.viol_held
		& state_reg.decode_ctl[WP_IRQ_BIT];
	assign nx_violation = state_reg.nx_pulse;

	// R5 R6 R20 echo engine
	gp_echo_engine echo (
		.clock        (clock),
		.reset        (reset),
		.enable       (echo_on),
		.start        (periph_start),
		.start_addr   (periph_addr),
		.start_write  (periph_write),
		.start_wdata  (periph_wdata),
		.periph_rdata (periph_rdata),
		.native_done  (periph_native_done),
		.cycle_clocks (gp_cycle_clocks),
		.done         (periph_done),
		.gp_bus       (gp_bus)
	);

endmodule

// [test/gp_bus_monitor.sv]
// Purpose: passive analyzer that records echoed general-purpose bus cycles
// Assumes: one echo cycle is a run of clocks with a strobe high
// Notes:   keeps the last cycle's address, direction, read data and length
`timescale 1ns/1ps
module gp_bus_monitor
	import debug_vis_pkg::*;
(
	input  wire logic       clock,  // System clock
	input  wire gp_bus_type gp_bus, // Watched bus
	output int              cycles, // Echo cycles seen
	output logic [15:0]     addr,   // Last address
	output logic            wr,     // Last direction
	output logic [15:0]     data,   // Last read data
	output logic [7:0]      len     // Last strobe length
);
	logic active_reg;

	initial begin
		active_reg = 1'b0;
		cycles = 0;
		{addr, wr, data, len} = '0;
	end

	always @(posedge clock) begin
		active_reg <= gp_bus.rd || gp_bus.wr;
		if ((gp_bus.rd || gp_bus.wr) && !active_reg) begin
			cycles <= cycles + 1;
			addr <= gp_bus.addr;
			wr <= gp_bus.wr;
			len <= 8'h01;
		end else if (gp_bus.rd || gp_bus.wr) begin
			len <= len + 8'h01;
		end
		// Only driven read data is taken
		if (gp_bus.rd && gp_bus.data_oe)
			data <= gp_bus.data;
	end
endmodule

// [test/debug_visibility_chk.sv]
// Purpose: port-level assertions for the debug visibility block
// Assumes: single clock domain, reset asynchronous and active high
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
module debug_visibility_chk
	import debug_vis_pkg::*;
(
	input wire logic        clock,               // System clock
	input wire logic        reset,               // Async, high
	input wire bus_req_type bus_req,             // Bus requests
	input wire bus_req_type bus_grant,           // Bus grants
	input wire logic        both_buses_owned,    // Lock both
	input wire logic        periph_start,        // Periph access
	input wire logic [15:0] periph_addr,         // Its address
	input wire logic        periph_write,        // Its direction
	input wire logic        periph_done,         // Access end
	input wire gp_bus_type  gp_bus,              // Echo cycle
	input wire logic        write_buffer_enable, // WB on
	input wire logic        read_buffer_enable,  // RB on
	input wire logic        reset_seq_done,      // Reset end
	input wire logic        debug_entry_request, // Debug pulse
	input wire logic        mem_write_valid,     // Memory write
	input wire logic        mem_write_protected, // Region attr
	input wire logic [3:0]  sdram_byte_masks,    // To SDRAM
	input wire logic        wp_violation,        // WP pulse
	input wire logic        fetch_valid,         // Code fetch
	input wire logic        fetch_non_exec,      // Region attr
	input wire logic        nx_violation         // NX pulse
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_echo_begin;
		$rose(gp_bus.rd || gp_bus.wr) && $past(periph_start);
	endsequence

	chk_mask_force: assert property (
		mem_write_valid && mem_write_protected |-> sdram_byte_masks == 4'hF)
		else $error("protected write not masked");
	chk_wp_pulse: assert property (
		mem_write_valid && mem_write_protected |=> wp_violation)
		else $error("write violation missing");
	chk_nx_cause: assert property (
		nx_violation |-> $past(fetch_valid && fetch_non_exec))
		else $error("fetch violation without cause");
	chk_read_drive: assert property (
		gp_bus.rd |-> gp_bus.data_oe)
		else $error("echoed read not driving data");
	chk_buf_pair: assert property (
		write_buffer_enable == read_buffer_enable)
		else $error("buffer enables differ");
	chk_owner_alone: assert property (
		both_buses_owned |-> $onehot(bus_grant))
		else $error("shared grant while owning both");
	chk_lone_grant: assert property (
		$onehot(bus_req) |-> bus_grant == bus_req)
		else $error("lone requester not granted");
	chk_echo_addr: assert property (
		s_echo_begin |-> gp_bus.addr == $past(periph_addr)
			&& gp_bus.wr == $past(periph_write))
		else $error("echo address or direction wrong");
	chk_echo_close: assert property (
		periph_done |=> !(gp_bus.rd || gp_bus.wr))
		else $error("strobe after completion");
	chk_debug_cause: assert property (
		debug_entry_request |-> $past(reset_seq_done))
		else $error("debug entry without reset end");
endmodule

bind debug_visibility debug_visibility_chk i_chk (.*);

// [test/debug_visibility_tb.sv]
// Purpose: self-checking bench for the debug visibility block
// Assumes: 200 MHz clock, reset held for 8 cycles
// Notes:   echo length expected as programmed clocks plus one
`timescale 1ns/1ps
module debug_visibility_tb;
	import debug_vis_pkg::*;
	typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_type;
	row_type rows [8] = '{'{12'h023, 8'h5A, 8'h5A}, '{12'h040, 8'h01, 8'h01},
		'{12'h070, 8'h01, 8'h01}, '{12'h080, 8'h03, 8'h03},
		'{12'hC00, 8'h01, 8'h01}, '{12'hD72, 8'h01, 8'h01},
		'{12'hD74, 8'hFF, 8'h00}, '{12'h123, 8'hFF, 8'h00}};
	logic clock, reset, both_buses_owned, periph_start, periph_write;
	logic periph_native_done, periph_done, write_buffer_enable;
	logic read_buffer_enable, reset_seq_done, reset_cause_valid;
	logic debug_entry_request, sdram_write_done, ecc_override_active;
	logic mem_write_valid, mem_write_protected, wp_violation;
	logic wp_violation_irq, fetch_valid, fetch_non_exec, nx_violation;
	logic mon_wr;
	logic [15:0] periph_addr, periph_wdata, periph_rdata, mon_addr, mon_data;
	logic [7:0] reg_rdata, gp_cycle_clocks, reset_cause, ecc_override_code;
	logic [7:0] mon_len;
	logic [31:0] mem_write_addr;
	logic [3:0] sdram_mask_in, sdram_byte_masks;
	reg_req_type reg_req;
	bus_req_type bus_req, bus_grant;
	gp_bus_type gp_bus;
	int n_errors = 0;
	int compares = 0;
	int mon_cycles;

	debug_visibility i_dut (.*);
	gp_bus_monitor i_mon (.clock(clock), .gp_bus(gp_bus),
		.cycles(mon_cycles), .addr(mon_addr), .wr(mon_wr),
		.data(mon_data), .len(mon_len));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %0h", $time, what, got);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock) reg_req <= '{a, 1'b1, 1'b0, d};
		@(posedge clock) reg_req <= '0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		@(posedge clock) reg_req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge clock) reg_req <= '0;
		#1 chk(reg_rdata, e, "register read");
	endtask

	task automatic access(input logic w);
		int k;
		@(posedge clock) periph_start <= 1'b1;
		periph_write <= w;
		periph_addr <= w ? 16'h0F24 : 16'h0A30;
		@(posedge clock) periph_start <= 1'b0;
		#1;
		for (k = 0; k < 20 && periph_done !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		chk(k < 20, 1, "echo done");
		repeat (2) @(posedge clock);
	endtask

	task automatic hit(input logic [31:0] a);
		@(posedge clock) mem_write_valid <= 1'b1;
		mem_write_protected <= 1'b1;
		mem_write_addr <= a;
		#1 chk(sdram_byte_masks, 4'hF, "masks");
		@(posedge clock) mem_write_valid <= 1'b0;
		#1 chk(wp_violation, 1, "wp pulse");
	endtask

	task automatic final_report();
		$display("counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#50000;
		n_errors++;
		final_report();
	end

	initial begin
		reset = 1'b1;
		reg_req = '0;
		bus_req = '0;
		{periph_start, periph_write, periph_native_done, reset_seq_done,
			reset_cause_valid, sdram_write_done, mem_write_valid,
			mem_write_protected, fetch_valid, fetch_non_exec} = '0;
		{periph_addr, mem_write_addr, reset_cause} = '0;
		periph_wdata = 16'h3C5A;
		periph_rdata = 16'hA5C3;
		gp_cycle_clocks = 8'h02;
		sdram_mask_in = 4'h5;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		foreach (rows[i]) rdc(rows[i].a, 8'h00);
		chk({write_buffer_enable, read_buffer_enable}, 0, "buffers");
		chk(wp_violation_irq, 0, "irq after reset");
		@(posedge clock) bus_req <= 3'b010;
		#1 chk({bus_grant, both_buses_owned}, 4'b0101, "lone pci");
		@(posedge clock) bus_req <= 3'b111;
		#1 chk(bus_grant, 3'b010, "owner keeps");
		@(posedge clock) bus_req <= 3'b000;
		periph_start <= 1'b1;
		@(posedge clock) periph_start <= 1'b0;
		periph_native_done <= 1'b1;
		#1 chk(periph_done, 1, "native done");
		@(posedge clock) periph_native_done <= 1'b0;
		repeat (3) @(posedge clock);
		chk(mon_cycles, 0, "no echo when off");
		$display("test done: reset and arbiter");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e);
		end
		chk({write_buffer_enable, read_buffer_enable}, 2'b11, "bufs");
		chk({ecc_override_active, ecc_override_code}, 9'h15A, "ecc");
		$display("test done: register table");
		@(posedge clock) bus_req <= 3'b110;
		#1 chk(bus_grant, 3'b110, "concurrent");
		@(posedge clock) bus_req <= 3'b000;
		wr(12'h070, 8'h00);
		@(posedge clock) bus_req <= 3'b110;
		#1 chk(bus_grant, 3'b100, "nonconcurrent");
		@(posedge clock) bus_req <= 3'b000;
		wr(12'h040, 8'h00);
		#1 chk({write_buffer_enable, read_buffer_enable}, 0, "off");
		$display("test done: modes");
		access(1'b0);
		chk({mon_cycles[7:0], mon_addr, mon_wr}, 25'h021460, "read");
		chk(mon_data, 16'hA5C3, "echo data");
		chk(mon_len, gp_cycle_clocks + 8'h01, "echo length");
		access(1'b1);
		chk({mon_cycles[7:0], mon_addr, mon_wr}, 25'h41E49, "write");
		chk(mon_len, gp_cycle_clocks + 8'h01, "echo length");
		$display("test done: echo");
		@(posedge clock) sdram_write_done <= 1'b1;
		@(posedge clock) sdram_write_done <= 1'b0;
		#1 chk(ecc_override_active, 0, "ecc one shot");
		@(posedge clock) reset_seq_done <= 1'b1;
		@(posedge clock) reset_seq_done <= 1'b0;
		#1 chk(debug_entry_request, 1, "debug entry");
		@(posedge clock) reset_cause_valid <= 1'b1;
		reset_cause <= 8'h24;
		@(posedge clock) reset_cause_valid <= 1'b0;
		rdc(12'hD74, 8'h24);
		$display("test done: ecc, debug, cause");
		hit(32'h1234_5678);
		hit(32'h0BAD_F00D);
		rdc(12'hD80, 8'h78);
		rdc(12'hD83, 8'h12);
		chk(wp_violation_irq, 1, "irq");
		wr(12'hD80, 8'h00);
		hit(32'h0BAD_F00D);
		rdc(12'hD80, 8'h0D);
		@(posedge clock) fetch_valid <= 1'b1;
		fetch_non_exec <= 1'b1;
		@(posedge clock) fetch_valid <= 1'b0;
		#1 chk(nx_violation, 1, "nx");
		$display("test done: protection");
		@(posedge clock) mem_write_protected <= 1'b0;
		mem_write_valid <= 1'b1;
		#1 chk(sdram_byte_masks, 4'h5, "masks pass");
		@(posedge clock) mem_write_valid <= 1'b0;
		#1 chk(wp_violation, 0, "no wp pulse");
		@(posedge clock) reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		#1 chk({write_buffer_enable, read_buffer_enable}, 0, "bufs");
		chk(wp_violation_irq, 0, "irq cleared");
		rdc(12'h070, 8'h00);
		rdc(12'hC00, 8'h00);
		$display("test done: mid-run reset");
		final_report();
	end
endmodule
